// >>> common/reset_wake_pkg.sv
package reset_wake_pkg;
    // operating modes of the analog die
    typedef enum logic [2:0] {M_POWER_ON, M_RESET, M_NORMAL, M_STOP, M_SLEEP} mode_e;
    // wake-up configuration held by the register file
    typedef struct packed {
        logic [5:0] wake_input_enable;
        logic [1:0] cyclic_sense_select;
        logic [3:0] forced_wake_multiplier;
        logic [7:0] cyclic_sense_timing;
    } wake_cfg_s;
    // wake-up source flags
    typedef struct packed {
        logic forced;
        logic wake_input;
        logic lin;
    } wake_src_s;
    // whole state of the controller
    typedef struct packed {
        mode_e mode;
        logic [2:0][10:0] sync;
        logic [10:0] stab;
        logic [5:0] flags;
        logic [7:0] rdata;
        logic rvalid;
        logic irq;
        logic wsr_pend;
        wake_src_s src;
        logic [23:0] rst_cnt;
        logic [23:0] lin_cnt;
        logic [23:0] rel_cnt;
        logic [23:0] pre_cnt;
        logic [7:0] per_cnt;
        logic [7:0] hs_cnt;
        logic [3:0] fw_cnt;
        logic [5:0] ref_smp;
        logic ref_ok;
        logic [1:0] hs;
        logic [5:0] ana_dis;
        logic rst_oe;
    } core_state_s;
endpackage : reset_wake_pkg

// >>> common/reset_wake_regs.svh
`ifndef RESET_WAKE_REGS_SVH
`define RESET_WAKE_REGS_SVH
// ------------------------------------------------------------
// register map and cause flag layout
// ------------------------------------------------------------
`define CAUSE_ADDR 8'h15
`define CAUSE_RST_VAL 6'h01
`define BIT_POR 0
`define BIT_CORE 1
`define BIT_IO 2
`define BIT_WAKE 3
`define BIT_EXT 4
`define BIT_WD 5
// ------------------------------------------------------------
// mode field codes of the mode control register
// ------------------------------------------------------------
`define MODE_REQ_NORMAL 2'h0
`define MODE_REQ_STOP 2'h1
`define MODE_REQ_SLEEP 2'h2
// ------------------------------------------------------------
// synchronised input vector positions
// ------------------------------------------------------------
`define IN_LIN 10
`define IN_RST 9
`define IN_POR 8
`define IN_CORE 7
`define IN_IO 6
`define IN_NUM 11
// ------------------------------------------------------------
// timing, in ns, and derived cycle counts
// ------------------------------------------------------------
`define CLK_NS 4
`define RST_FILT_NS 1000
`define RST_FILT_CYC ((`RST_FILT_NS + `CLK_NS - 1) / `CLK_NS)
`define LIN_WAKE_NS 80000
`define LIN_WAKE_CYC ((`LIN_WAKE_NS + `CLK_NS - 1) / `CLK_NS)
`define RST_REL_NS 1000000
`define RST_REL_CYC ((`RST_REL_NS + `CLK_NS - 1) / `CLK_NS)
`define TICK_NS 1000000
`define TICK_CYC (`TICK_NS / `CLK_NS)
`define HS_ON_NS 200
`define HS_ON_CYC ((`HS_ON_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// >>> rtl/reset_wake_ctrl.sv
// Function
// - sleep wake-up event enters reset mode
// - filtered low reset line raises external reset
// - watchdog fault resets normal or stop mode, flag recorded
// - cause register bit layout, top bits zero
// - read returns flags then clears; writes ignored
// - supply low flags masked by power-on/wake
// - stop wake-up raises interrupt, enters normal
// - stop refused until wake source read
// - enabled wake input change wakes, sensing off
// - selected wake pins lose analog function
// - cyclic sense pulses high-side, samples inputs
// - low power overrides high-side control register
// - simultaneous forced and input: forced reported
// - cyclic mode compares consecutive event samples
// - trimmed tick in stop, untrimmed in sleep
// - nonzero multiplier gives periodic forced wake
// - lin wake after long dominant, then recessive
// - normal request wakes stop, no source bit
// - stop: core low or external reset enters reset
// - sleep: main supply loss enters power on
// - reset line held for release time after
// - reset mode defaults registers except cause/source
`timescale 1ns/10ps
`include "reset_wake_regs.svh"
`default_nettype none
module reset_wake_ctrl
    import reset_wake_pkg::*;
#(
    parameter int LIN_CYC = `LIN_WAKE_CYC,
    parameter int REL_CYC = `RST_REL_CYC,
    parameter int TRIM_DIV = `TICK_CYC,
    parameter int UNTRIM_DIV = `TICK_CYC
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // cause register read port
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // mode requests and wake-up configuration
    input wire logic mode_cmd_valid_i,
    input wire logic [1:0] mode_cmd_i,
    input wire logic wsr_read_i,
    input var wake_cfg_s wake_cfg_i,
    input wire logic [1:0] high_side_ctrl_i,
    // analog and pin inputs, asynchronous
    input wire logic [5:0] wake_input_i,
    input wire logic lin_rx_i,
    input wire logic main_supply_low_i,
    input wire logic core_supply_low_i,
    input wire logic io_supply_low_i,
    input wire logic reset_line_i,
    // same-domain watchdog fault pulse
    input wire logic wd_fault_i,
    // reset line, open drain
    output logic reset_line_o,
    output logic reset_line_oe_o,
    // status and drive outputs
    output mode_e mode_o,
    output logic die_regs_default_o,
    output logic die_link_interrupt_o,
    output logic wsr_pending_o,
    output wake_src_s wake_source_o,
    output logic [1:0] high_side_o,
    output logic [5:0] analog_in_disable_o
);
    // ------------------------------------------------------------
    // state and helpers
    // ------------------------------------------------------------
    localparam core_state_s RST_STATE = '{
        mode: M_POWER_ON,
        flags: `CAUSE_RST_VAL,
        rst_oe: 1'b1,
        default: '0
    };

    core_state_s s; // registered state
    core_state_s n; // next state
    logic rd_hit; // read of the cause register
    logic lp; // stop or sleep
    logic tick; // slow sense tick
    logic cyc_evt; // cyclic sense sample point
    logic forced; // forced wake-up this cycle
    logic lx_chg; // wake input change this cycle
    logic lin_wake; // lin wake-up this cycle
    logic ext_rst; // filtered external reset
    logic wake_any; // any wake source with status bit
    logic [5:0] set; // cause flags raised this cycle
    logic [5:0] vis; // flags as seen on a read
    logic [5:0] diff; // enabled wake input differences
    logic [23:0] div; // current tick divider

    // saturating increment keeps long counters from wrapping
    function automatic logic [23:0] sat_inc(input logic [23:0] v);
        return (v == 24'hFF_FFFF) ? v : v + 24'h00_0001;
    endfunction : sat_inc

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        n = s;
        tick = 1'b0;
        cyc_evt = 1'b0;
        forced = 1'b0;
        lx_chg = 1'b0;
        rd_hit = reg_rd_i && (reg_addr_i == `CAUSE_ADDR);
        lp = (s.mode == M_STOP) || (s.mode == M_SLEEP);

        // three-stage synchronisers; a change counts when stages two and three agree
        n.sync[0] = {lin_rx_i, reset_line_i, main_supply_low_i, core_supply_low_i,
                     io_supply_low_i, wake_input_i};
        n.sync[1] = s.sync[0];
        n.sync[2] = s.sync[1];
        for (int i = 0; i < `IN_NUM; i++) begin
            if (s.sync[1][i] == s.sync[2][i]) begin
                n.stab[i] = s.sync[2][i];
            end
        end

        // external reset filter; our own drive is not an external event
        if (!s.stab[`IN_RST] && !s.rst_oe) begin
            n.rst_cnt = sat_inc(s.rst_cnt);
        end else begin
            n.rst_cnt = '0;
        end
        ext_rst = !s.stab[`IN_RST] && (s.rst_cnt == 24'(`RST_FILT_CYC));

        // slow tick: trimmed divider in stop, untrimmed in sleep
        div = (s.mode == M_STOP) ? 24'(TRIM_DIV) : 24'(UNTRIM_DIV);
        if (lp && (s.pre_cnt >= div - 24'h00_0001)) begin
            n.pre_cnt = '0;
            tick = 1'b1;
        end else if (lp) begin
            n.pre_cnt = s.pre_cnt + 24'h00_0001;
        end else begin
            n.pre_cnt = '0;
        end

        // cyclic period; also runs for forced wake-up alone
        if (lp && tick && (s.hs_cnt == 8'h00) &&
            ((wake_cfg_i.cyclic_sense_select != 2'b00) ||
             (wake_cfg_i.forced_wake_multiplier != 4'h0))) begin
            if (s.per_cnt + 8'h01 >= wake_cfg_i.cyclic_sense_timing) begin
                n.per_cnt = '0;
                n.hs_cnt = 8'(`HS_ON_CYC);
            end else begin
                n.per_cnt = s.per_cnt + 8'h01;
            end
        end
        // sense window: sample on its last cycle while the outputs still power the inputs
        if (s.hs_cnt != 8'h00) begin
            n.hs_cnt = s.hs_cnt - 8'h01;
            // a window cut short by another wake source must not sample in normal mode
            cyc_evt = lp && (s.hs_cnt == 8'h01);
        end
        // high-side drive: low power ignores the control register
        if (lp) begin
            n.hs = (s.hs_cnt != 8'h00) ? wake_cfg_i.cyclic_sense_select : 2'b00;
        end else begin
            n.hs = high_side_ctrl_i;
        end

        // forced wake-up every multiplier times the cyclic period
        if (cyc_evt && (wake_cfg_i.forced_wake_multiplier != 4'h0)) begin
            if ({1'b0, s.fw_cnt} + 5'h01 >= {1'b0, wake_cfg_i.forced_wake_multiplier}) begin
                n.fw_cnt = '0;
                forced = 1'b1;
            end else begin
                n.fw_cnt = s.fw_cnt + 4'h1;
            end
        end

        // wake input change detection
        diff = (s.stab[5:0] ^ s.ref_smp) & wake_cfg_i.wake_input_enable;
        if (wake_cfg_i.cyclic_sense_select == 2'b00) begin
            lx_chg = lp && (|diff);
        end else if (cyc_evt) begin
            lx_chg = s.ref_ok && (|diff);
            n.ref_smp = s.stab[5:0];
            n.ref_ok = 1'b1;
        end

        // lin: long dominant (low) then recessive edge; short-to-ground never wakes
        if (lp && !s.stab[`IN_LIN]) begin
            n.lin_cnt = sat_inc(s.lin_cnt);
        end else begin
            n.lin_cnt = '0;
        end
        lin_wake = lp && s.stab[`IN_LIN] && (s.lin_cnt > 24'(LIN_CYC));
        wake_any = lx_chg || forced || lin_wake;

        // cause flags: set wins over the clearing read
        set = '0;
        set[`BIT_POR] = s.stab[`IN_POR];
        set[`BIT_CORE] = s.stab[`IN_CORE];
        set[`BIT_IO] = s.stab[`IN_IO];
        set[`BIT_WAKE] = (s.mode == M_SLEEP) && wake_any;
        set[`BIT_EXT] = ext_rst;
        set[`BIT_WD] = wd_fault_i;
        vis = s.flags;
        if (s.flags[`BIT_POR] || s.flags[`BIT_WAKE]) begin
            vis[`BIT_IO] = 1'b0;
            vis[`BIT_CORE] = 1'b0;
        end
        n.rvalid = rd_hit;
        if (rd_hit) begin
            n.rdata = {2'b00, vis};
        end
        n.flags = (rd_hit ? 6'h00 : s.flags) | set;

        // wake source register; a new wake-up wins over its read
        if (wsr_read_i) begin
            n.wsr_pend = 1'b0;
            n.src = '0;
            n.irq = 1'b0;
        end
        if (lp && wake_any) begin
            n.wsr_pend = 1'b1;
            n.src.forced = n.src.forced | forced;
            n.src.wake_input = n.src.wake_input | (lx_chg && !forced);
            n.src.lin = n.src.lin | lin_wake;
        end

        // mode sequencing
        case (s.mode)
            M_POWER_ON: begin
                if (!s.stab[`IN_POR]) begin
                    n.mode = M_RESET;
                end
            end
            M_RESET: begin
                if (s.stab[`IN_POR]) begin
                    n.mode = M_POWER_ON;
                end else if (s.stab[`IN_CORE] || s.stab[`IN_IO]) begin
                    n.rel_cnt = '0; // condition still present
                end else if (s.rel_cnt >= 24'(REL_CYC)) begin
                    n.mode = M_NORMAL;
                    n.rel_cnt = '0;
                end else begin
                    n.rel_cnt = sat_inc(s.rel_cnt);
                end
            end
            M_NORMAL: begin
                if (s.stab[`IN_POR]) begin
                    n.mode = M_POWER_ON;
                end else if (s.stab[`IN_CORE] || s.stab[`IN_IO] || ext_rst || wd_fault_i) begin
                    n.mode = M_RESET;
                end else if (mode_cmd_valid_i && (mode_cmd_i == `MODE_REQ_STOP) &&
                             !s.wsr_pend) begin
                    n.mode = M_STOP;
                end else if (mode_cmd_valid_i && (mode_cmd_i == `MODE_REQ_SLEEP)) begin
                    n.mode = M_SLEEP;
                end
            end
            M_STOP: begin
                if (s.stab[`IN_POR]) begin
                    n.mode = M_POWER_ON;
                end else if (s.stab[`IN_CORE] || ext_rst || wd_fault_i) begin
                    n.mode = M_RESET;
                end else if (wake_any) begin
                    n.mode = M_NORMAL;
                    n.irq = 1'b1;
                end else if (mode_cmd_valid_i && (mode_cmd_i == `MODE_REQ_NORMAL)) begin
                    n.mode = M_NORMAL;
                end
            end
            M_SLEEP: begin
                if (s.stab[`IN_POR]) begin
                    n.mode = M_POWER_ON;
                end else if (wake_any) begin
                    n.mode = M_RESET;
                end
            end
            default: begin
                n.mode = M_RESET;
            end
        endcase

        // low-power entry: fresh reference and counters, analog function off on enabled wake inputs
        if (!lp && ((n.mode == M_STOP) || (n.mode == M_SLEEP))) begin
            n.ref_smp = s.stab[5:0];
            n.ref_ok = 1'b0;
            n.per_cnt = '0;
            n.fw_cnt = '0;
            n.hs_cnt = '0;
            n.pre_cnt = '0;
            n.ana_dis = wake_cfg_i.wake_input_enable;
        end else if ((n.mode != M_STOP) && (n.mode != M_SLEEP)) begin
            n.ana_dis = '0;
        end
        // reset line and register defaults follow reset and power-on modes
        n.rst_oe = (n.mode == M_RESET) || (n.mode == M_POWER_ON);
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s <= RST_STATE;
        end else begin
            s <= n;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign reg_rdata_o = s.rdata;
    assign reg_rvalid_o = s.rvalid;
    assign reset_line_o = 1'b0; // open drain only ever pulls low
    assign reset_line_oe_o = s.rst_oe;
    assign die_regs_default_o = s.rst_oe;
    assign mode_o = s.mode;
    assign die_link_interrupt_o = s.irq;
    assign wsr_pending_o = s.wsr_pend;
    assign wake_source_o = s.src;
    assign high_side_o = s.hs;
    assign analog_in_disable_o = s.ana_dis;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_stop_entry;
        (s.mode == M_NORMAL) && mode_cmd_valid_i && (mode_cmd_i == `MODE_REQ_STOP) &&
        !s.wsr_pend && !s.stab[`IN_POR] && !s.stab[`IN_CORE] && !s.stab[`IN_IO] &&
        !ext_rst && !wd_fault_i;
    endsequence
    sequence s_cause_read;
        rd_hit ##1 reg_rvalid_o;
    endsequence

    property p_sleep_wake;
        (s.mode == M_SLEEP) && wake_any && !s.stab[`IN_POR] |=> (s.mode == M_RESET);
    endproperty
    a_sleep_wake: assert property (p_sleep_wake) else $error("sleep wake not reset");
    property p_ext_rst;
        ext_rst |=> s.flags[`BIT_EXT];
    endproperty
    a_ext_rst: assert property (p_ext_rst) else $error("external reset lost");
    property p_wd;
        wd_fault_i && (s.mode == M_NORMAL) |=> s.flags[`BIT_WD] && (s.mode == M_RESET);
    endproperty
    a_wd: assert property (p_wd) else $error("watchdog reset missing");
    property p_layout;
        s_cause_read |-> (reg_rdata_o[7:6] == 2'b00) && (reg_rdata_o[5:0] == $past(vis));
    endproperty
    a_layout: assert property (p_layout) else $error("cause read value wrong");
    property p_clear;
        rd_hit && (set == 6'h00) |=> (s.flags == 6'h00);
    endproperty
    a_clear: assert property (p_clear) else $error("cause flags not cleared");
    property p_mask;
        rd_hit && (s.flags[`BIT_POR] || s.flags[`BIT_WAKE]) |=> (reg_rdata_o[2:1] == 2'b00);
    endproperty
    a_mask: assert property (p_mask) else $error("supply low flags not masked");
    property p_stop_wake;
        (s.mode == M_STOP) && wake_any && !s.stab[`IN_POR] && !s.stab[`IN_CORE] &&
        !ext_rst && !wd_fault_i |=> die_link_interrupt_o && (s.mode == M_NORMAL);
    endproperty
    a_stop_wake: assert property (p_stop_wake) else $error("stop wake not signalled");
    property p_stop_refused;
        (s.mode == M_NORMAL) && s.wsr_pend |=> (s.mode != M_STOP);
    endproperty
    a_stop_refused: assert property (p_stop_refused) else $error("stop taken too early");
    property p_stop_entry;
        s_stop_entry |=> (s.mode == M_STOP) && (analog_in_disable_o ==
            $past(wake_cfg_i.wake_input_enable));
    endproperty
    a_stop_entry: assert property (p_stop_entry) else $error("stop entry wrong");
    property p_forced_only;
        forced && lx_chg && !wsr_read_i && (s.src == 3'b000) |=>
            wake_source_o.forced && !wake_source_o.wake_input;
    endproperty
    a_forced_only: assert property (p_forced_only) else $error("forced not sole source");
    property p_release;
        $fell(reset_line_oe_o) |-> ($past(s.rel_cnt) >= 24'(REL_CYC));
    endproperty
    a_release: assert property (p_release) else $error("reset line released early");
endmodule : reset_wake_ctrl
`default_nettype wire

// >>> tb/host_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_model (
    // clock
    input wire logic core_clk_i,
    // requests toward the die
    output logic reg_rd_o,
    output logic [7:0] reg_addr_o,
    output logic mode_cmd_valid_o,
    output logic [1:0] mode_cmd_o,
    output logic wsr_read_o,
    // answers from the die
    input wire logic [7:0] reg_rdata_i,
    input wire logic reg_rvalid_i
);
    // idle bus from time zero
    initial begin
        reg_rd_o = 1'b0;
        reg_addr_o = 8'h00;
        mode_cmd_valid_o = 1'b0;
        mode_cmd_o = 2'h0;
        wsr_read_o = 1'b0;
    end
    // one-cycle strobe; the address is inverted after it so a stale value never matches
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] d, output logic ok);
        ok = 1'b0;
        d = 8'h00;
        @(negedge core_clk_i);
        reg_rd_o = 1'b1;
        reg_addr_o = addr;
        @(negedge core_clk_i);
        reg_rd_o = 1'b0;
        reg_addr_o = ~addr;
        repeat (3) begin
            if (reg_rvalid_i === 1'b1 && !ok) begin
                ok = 1'b1;
                d = reg_rdata_i;
            end
            @(negedge core_clk_i);
        end
    endtask : read_reg
    // mode field write; the field is scrambled once the pulse is over
    task automatic mode_req(input logic [1:0] m);
        @(negedge core_clk_i);
        mode_cmd_valid_o = 1'b1;
        mode_cmd_o = m;
        @(negedge core_clk_i);
        mode_cmd_valid_o = 1'b0;
        mode_cmd_o = ~m;
        @(negedge core_clk_i);
    endtask : mode_req
    // source read, then the gap owed before any mode write
    task automatic ack_wake();
        @(negedge core_clk_i);
        wsr_read_o = 1'b1;
        @(negedge core_clk_i);
        wsr_read_o = 1'b0;
        repeat (2) @(negedge core_clk_i);
    endtask : ack_wake
endmodule : host_model
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/10ps
`include "reset_wake_regs.svh"
`default_nettype none
module tb import reset_wake_pkg::*; ();
    localparam int LIN = 20;
    localparam int REL = 30;
    // one stop-mode wake case: config, stimulus kind, expected outcome
    typedef struct packed {
        wake_cfg_s cfg;
        logic [1:0] how;
        logic after_win;
        logic [5:0] tgl;
        wake_src_s src;
        logic irq;
        logic [1:0] hs;
    } row_s;
    logic core_clk, rst_n, reg_rd, reg_rvalid, mode_cmd_valid, wsr_read, lin_rx, main_low;
    logic core_low, io_low, wd_fault, ext_low, rl_o, rl_oe, rst_line, regs_def, irq, wsr_pend;
    logic [7:0] reg_addr, reg_rdata;
    logic [1:0] mode_cmd, hs_ctrl, hs, hs_seen;
    logic [5:0] pins, ana_dis;
    wake_cfg_s cfg;
    wake_src_s src;
    mode_e mode;
    int err_count = 0;
    int tests_run = 0;
    // pulled-up reset line: low while the die or the outside world pulls it
    assign rst_line = !((rl_oe && !rl_o) || ext_low);
    // how: 0 nothing beyond the tgl pin toggle, 1 lin pulse, 2 normal request
    row_s rows [7] = '{
        '{{6'h01, 2'h0, 4'h0, 8'h01}, 2'h0, 1'b0, 6'h01, 3'h2, 1'b1, 2'h0},
        '{{6'h20, 2'h0, 4'h0, 8'h01}, 2'h0, 1'b0, 6'h21, 3'h2, 1'b1, 2'h0},
        '{{6'h00, 2'h1, 4'h1, 8'h01}, 2'h0, 1'b0, 6'h00, 3'h4, 1'b1, 2'h1},
        '{{6'h01, 2'h2, 4'h2, 8'h01}, 2'h0, 1'b1, 6'h01, 3'h4, 1'b1, 2'h2},
        '{{6'h02, 2'h3, 4'h0, 8'h02}, 2'h0, 1'b1, 6'h02, 3'h2, 1'b1, 2'h3},
        '{{6'h00, 2'h0, 4'h0, 8'h01}, 2'h1, 1'b0, 6'h00, 3'h1, 1'b1, 2'h0},
        '{{6'h00, 2'h0, 4'h0, 8'h01}, 2'h2, 1'b0, 6'h00, 3'h0, 1'b0, 2'h0}
    };
    host_model host_i (.core_clk_i(core_clk), .reg_rd_o(reg_rd), .reg_addr_o(reg_addr),
        .mode_cmd_valid_o(mode_cmd_valid), .mode_cmd_o(mode_cmd), .wsr_read_o(wsr_read),
        .reg_rdata_i(reg_rdata), .reg_rvalid_i(reg_rvalid));
    reset_wake_ctrl #(.LIN_CYC(LIN), .REL_CYC(REL), .TRIM_DIV(8), .UNTRIM_DIV(8))
    reset_wake_ctrl_i (.core_clk_i(core_clk), .rst_n_i(rst_n), .reg_rd_i(reg_rd),
        .reg_addr_i(reg_addr), .reg_rdata_o(reg_rdata), .reg_rvalid_o(reg_rvalid),
        .mode_cmd_valid_i(mode_cmd_valid), .mode_cmd_i(mode_cmd), .wsr_read_i(wsr_read),
        .wake_cfg_i(cfg), .high_side_ctrl_i(hs_ctrl), .wake_input_i(pins), .lin_rx_i(lin_rx),
        .main_supply_low_i(main_low), .core_supply_low_i(core_low), .io_supply_low_i(io_low),
        .reset_line_i(rst_line), .wd_fault_i(wd_fault), .reset_line_o(rl_o),
        .reset_line_oe_o(rl_oe), .mode_o(mode), .die_regs_default_o(regs_def),
        .die_link_interrupt_o(irq), .wsr_pending_o(wsr_pend), .wake_source_o(src),
        .high_side_o(hs), .analog_in_disable_o(ana_dis));
    // 4 ns clock
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // verdict and end of run
    task automatic summarize();
        $display("counts: %0d compares, %0d mismatches", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : summarize
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // bounded wait for a mode; running out ends the run
    task automatic wait_mode(input mode_e m, input int lim);
        for (int k = 0; k < lim && mode !== m; k++) @(negedge core_clk);
        if (mode !== m) begin
            err_count++;
            $display("MISMATCH at %0t: mode wait ran out", $time);
            summarize();
        end
    endtask : wait_mode
    // read the cause register and compare it
    task automatic cause(input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        host_i.read_reg(`CAUSE_ADDR, d, ok);
        chk({7'h00, ok}, 8'h01);
        chk(d, exp);
    endtask : cause
    // supply fault pulse {main, core, io}, mode checked while it lasts
    task automatic hit(input logic [2:0] m, input mode_e exp);
        {main_low, core_low, io_low} = m;
        repeat (10) @(negedge core_clk);
        chk(8'(mode), 8'(exp));
        {main_low, core_low, io_low} = 3'h0;
        wait_mode(M_NORMAL, 300);
    endtask : hit
    task automatic do_reset();
        rst_n = 1'b0;
        repeat (6) @(negedge core_clk);
        chk({5'h00, mode == M_POWER_ON, rl_oe, regs_def}, 8'h07);
        rst_n = 1'b1;
        wait_mode(M_NORMAL, 200);
    endtask : do_reset
    initial begin
        row_s r;
        logic [7:0] d;
        logic ok, on;
        int n;
        {rst_n, lin_rx, main_low, core_low, io_low, wd_fault, ext_low} = 7'h20;
        {cfg, hs_ctrl, pins} = '0;
        hs_ctrl = 2'h3;
        do_reset();
        host_i.ack_wake();
        // ---- table of stop-mode wake cases ----
        foreach (rows[i]) begin
            r = rows[i];
            cfg = r.cfg;
            host_i.mode_req(`MODE_REQ_STOP);
            chk(8'(mode), 8'(M_STOP));
            chk({2'h0, ana_dis}, {2'h0, r.cfg.wake_input_enable});
            @(negedge core_clk);
            chk({6'h00, hs}, 8'h00);
            hs_seen = 2'h0;
            on = 1'b0;
            // let the first sense window pass: its sample is only the reference
            for (int k = 0; k < 400 && r.after_win && !(on && hs === 2'h0); k++) begin
                on |= (hs != 2'h0);
                hs_seen |= hs;
                @(negedge core_clk);
            end
            pins ^= r.tgl;
            if (r.after_win) begin
                repeat (8) @(negedge core_clk);
                chk(8'(mode), 8'(M_STOP));
            end
            if (r.how == 2'h1) begin
                lin_rx = 1'b0;
                repeat (LIN + 10) @(negedge core_clk);
                chk(8'(mode), 8'(M_STOP));
                lin_rx = 1'b1;
            end
            if (r.how == 2'h2) host_i.mode_req(`MODE_REQ_NORMAL);
            for (int k = 0; k < 1000 && mode !== M_NORMAL; k++) begin
                hs_seen |= hs;
                @(negedge core_clk);
            end
            chk(8'(mode), 8'(M_NORMAL));
            chk({7'h00, irq}, {7'h00, r.irq});
            chk(8'(src), 8'(r.src));
            chk({6'h00, hs_seen}, {6'h00, r.hs});
            if (r.irq) begin
                host_i.mode_req(`MODE_REQ_STOP);
                chk(8'(mode), 8'(M_NORMAL));
            end
            host_i.ack_wake();
            chk({4'h0, irq, src}, 8'h00);
            $display("done: wake case %0d", i);
        end
        // ---- cause register after reset, then the awkward cases ----
        do_reset();
        cause(8'h01);
        cause(8'h00);
        host_i.read_reg(8'h16, d, ok);
        chk({7'h00, ok}, 8'h00);
        hit(3'h1, M_RESET);
        hit(3'h2, M_RESET);
        cause(8'h06);
        hit(3'h4, M_POWER_ON);
        hit(3'h1, M_RESET);
        cause(8'h01);
        $display("done: supply causes");
        ext_low = 1'b1;
        repeat (200) @(negedge core_clk);
        chk(8'(mode), 8'(M_NORMAL));
        wait_mode(M_RESET, 100);
        chk(8'(mode), 8'(M_RESET));
        ext_low = 1'b0;
        wait_mode(M_NORMAL, 300);
        wd_fault = 1'b1;
        @(negedge core_clk);
        wd_fault = 1'b0;
        n = 0;
        for (int k = 0; k < 300 && mode !== M_NORMAL; k++) begin
            n += int'(rl_oe === 1'b1);
            @(negedge core_clk);
        end
        chk({7'h00, n >= REL}, 8'h01);
        cause(8'h30);
        $display("done: pin and watchdog");
        cfg = '0;
        host_i.mode_req(`MODE_REQ_STOP);
        hit(3'h2, M_RESET);
        cause(8'h02);
        cfg = {6'h01, 2'h0, 4'h0, 8'h01};
        host_i.ack_wake();
        host_i.mode_req(`MODE_REQ_SLEEP);
        chk(8'(mode), 8'(M_SLEEP));
        pins ^= 6'h01;
        wait_mode(M_RESET, 100);
        wait_mode(M_NORMAL, 300);
        chk(8'(src), 8'h02);
        cause(8'h08);
        host_i.ack_wake();
        host_i.mode_req(`MODE_REQ_SLEEP);
        hit(3'h4, M_POWER_ON);
        $display("done: sleep exits");
        summarize();
    end
endmodule : tb
`default_nettype wire
